// File: src/atf_defs.vh
// atf_defs.vh: offsets, bit positions and codes of the task-file bank
// assumes: included by src/atf_task_file.v only
`ifndef ATF_DEFS_VH
`define ATF_DEFS_VH

// register offsets
`define ATF_OFS_SECTOR 4'h3
`define ATF_OFS_CYL_LO 4'h4
`define ATF_OFS_CYL_HI 4'h5
`define ATF_OFS_UNIT_HEAD 4'h6
`define ATF_OFS_STATUS 4'h7
`define ATF_OFS_CONTROL 4'hE
`define ATF_OFS_UNIT_ADDR 4'hF

// unit/head register fields
`define ATF_UH_FIX7 7
`define ATF_UH_LBA 6
`define ATF_UH_FIX5 5
`define ATF_UH_UNIT 4
`define ATF_UH_HEAD_HI 3
`define ATF_UH_HEAD_LO 0
`define ATF_UH_FIXED 8'hA0

// status fields
`define ATF_ST_BUSY 7
`define ATF_ST_RDY 6
`define ATF_ST_DWF 5
`define ATF_ST_DSC 4
`define ATF_ST_DRQ 3
`define ATF_ST_FIXED_DATA_FLAG 2
`define ATF_ST_IDX 1
`define ATF_ST_ERR 0

// control fields
`define ATF_CT_SRST 2
`define ATF_CT_IEN_N 1

// unit address readback fields
`define ATF_UA_WTG_N 6

// error register field
`define ATF_ER_ABORTED_FLAG 2

// reset values
`define ATF_RST_BYTE 8'h00
`define ATF_RST_UNIT_HEAD 8'hA0
`define ATF_UNMAPPED_READ 8'h00

// smart feature codes
`define ATF_SM_READ_DATA 8'hD0
`define ATF_SM_READ_THRESH 8'hD1
`define ATF_SM_AUTOSAVE 8'hD2
`define ATF_SM_READ_LOG 8'hD5
`define ATF_SM_WRITE_LOG 8'hD6
`define ATF_SM_ENABLE 8'hD8
`define ATF_SM_DISABLE 8'hD9
`define ATF_SM_STATUS 8'hDA

// smart signature bytes
`define ATF_SIG_LO 8'h4F
`define ATF_SIG_HI 8'hC2

// smart operation codes to the firmware side
`define ATF_OP_NONE 3'h0
`define ATF_OP_READ_DATA 3'h1
`define ATF_OP_READ_THRESH 3'h2
`define ATF_OP_AUTOSAVE 3'h3
`define ATF_OP_READ_LOG 3'h4
`define ATF_OP_WRITE_LOG 3'h5
`define ATF_OP_ENABLE 3'h6
`define ATF_OP_DISABLE 3'h7

`endif

// File: src/atf_task_file.v
// atf_task_file.v: task-file register bank with address assembly,
// status, control, unit address readback and smart decode.
// assumes: host strobes come from interface logic on clk_sys, one cycle
// each; core flags and events are on clk_sys; smart setting storage
// is an outside non-volatile cell reached by a value level and a load pulse.
`timescale 1ns/100ps
`default_nettype none
`include "atf_defs.vh"

// Functional notes
// - offset 3 holds start sector or address bits 7..0.
// - offset 4 holds cylinder low or address bits 15..8.
// - offset 5 holds cylinder high or address bits 23..16.
// - unit/head bits 7 and 5 are always one.
// - unit/head bit 6 selects cylinder/head/sector (0) or block (1).
// - unit/head bits 3..0 are head number or address bits 27..24.
// - unit/head bit 4 selects unit 0 or unit 1.
// - status read at 7 clears pending interrupt; copy at Eh does not.
// - busy bit one means device owns command register and buffer.
// - ready bit clear from power-up until commands accepted.
// - status bit 5 reports a write fault.
// - status bit 3 requests a data word transfer.
// - status bit 2 reports a corrected error; reads continue.
// - status bit 1 reads zero; bit 0 flags previous command error.
// - control bit 2 holds soft reset until written back to zero.
// - control bit 1 masks interrupts when one; zero after reset.
// - readback bit 6 is zero while a write is in progress.
// - readback bits 5..2 invert unit/head bits 3..0.
// - readback bits 1,0 low when unit 1 or 0 active and selected.
// - smart sub-command decoded from the feature value.
// - smart enable/disable act only on matching signature bytes.
// - smart enabled setting kept in non-volatile storage.
// - invalid or blocked command sets abort error bit.
module atf_task_file (
    input wire clk_sys,
    input wire arst_n,
    // host register port
    input wire [3:0] reg_addr,
    input wire reg_rd,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // core state
    input wire core_busy,
    input wire core_ready,
    input wire data_request_flag,
    input wire write_fault_evt,
    input wire fixed_data_evt,
    input wire cmd_error_evt,
    input wire cmd_abort_evt,
    input wire cmd_start,
    input wire write_active,
    input wire [1:0] unit_present,
    input wire irq_evt,
    // smart command from the command register path
    input wire smart_cmd,
    input wire [7:0] feature_code,
    // non-volatile smart setting
    input wire smart_nv_state,
    output reg smart_nv_load,
    output reg smart_nv_value,
    // towards the core
    output reg [27:0] start_address,
    output reg lba_mode,
    output reg [3:0] head_number,
    output reg unit_select_bit,
    output reg soft_reset_active,
    output reg interrupt_mask_n,
    output wire card_irq,
    output reg [2:0] smart_op,
    output reg smart_op_valid,
    output reg smart_enabled,
    output reg aborted_flag
);

    reg rst_meta;
    reg rst_sync;
    reg [7:0] start_sector_lba_low;
    reg [7:0] cylinder_low_lba_mid;
    reg [7:0] cylinder_high_lba_high;
    reg [7:0] unit_head_select;
    reg ready_flag;
    reg write_fault_flag;
    reg fixed_data_flag;
    reg error_flag;
    reg irq_pending;
    reg nv_loaded;
    reg [7:0] next_rdata;
    reg [2:0] next_op;
    reg next_op_ok;
    wire [7:0] status_byte;
    wire [7:0] unit_address_readback;
    wire wr_hit_task;
    wire status_rd;
    wire smart_abort;
    wire sig_ok;

    // decode host write hit for a task-file offset
    function wr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        input wr;
        begin
            wr_hit = wr && (addr == ofs);
        end
    endfunction

    // reset release through two flops
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // task-file writes are dropped while the core owns the bank
    assign wr_hit_task = reg_wr && !core_busy;

    // address registers; host locked out while busy
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            start_sector_lba_low <= `ATF_RST_BYTE;
            cylinder_low_lba_mid <= `ATF_RST_BYTE;
            cylinder_high_lba_high <= `ATF_RST_BYTE;
            unit_head_select <= `ATF_RST_UNIT_HEAD;
        end else begin
            if (wr_hit(reg_addr, `ATF_OFS_SECTOR, wr_hit_task)) begin
                start_sector_lba_low <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ATF_OFS_CYL_LO, wr_hit_task)) begin
                cylinder_low_lba_mid <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ATF_OFS_CYL_HI, wr_hit_task)) begin
                cylinder_high_lba_high <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ATF_OFS_UNIT_HEAD, wr_hit_task)) begin
                unit_head_select <= reg_wdata | `ATF_UH_FIXED;
            end
        end
    end

    // address assembly for the next command
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            start_address <= 28'h0000000;
            lba_mode <= 1'b0;
            head_number <= 4'h0;
            unit_select_bit <= 1'b0;
        end else begin
            start_address <= {
                unit_head_select[`ATF_UH_HEAD_HI:`ATF_UH_HEAD_LO],
                cylinder_high_lba_high,
                cylinder_low_lba_mid,
                start_sector_lba_low};
            lba_mode <= unit_head_select[`ATF_UH_LBA];
            head_number <=
                unit_head_select[`ATF_UH_HEAD_HI:`ATF_UH_HEAD_LO];
            unit_select_bit <= unit_head_select[`ATF_UH_UNIT];
        end
    end

    // control register; writable even while busy so reset can break in
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            soft_reset_active <= 1'b0;
            interrupt_mask_n <= 1'b0;
        end else if (wr_hit(reg_addr, `ATF_OFS_CONTROL, reg_wr)) begin
            soft_reset_active <= reg_wdata[`ATF_CT_SRST];
            interrupt_mask_n <= reg_wdata[`ATF_CT_IEN_N];
        end
    end

    // status flags; a setting event wins over a clear, except that soft reset wins over core_ready for ready
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            ready_flag <= 1'b0;
            write_fault_flag <= 1'b0;
            fixed_data_flag <= 1'b0;
            error_flag <= 1'b0;
            aborted_flag <= 1'b0;
        end else begin
            // ready stays low for as long as soft reset is held
            if (soft_reset_active) begin
                ready_flag <= 1'b0;
            end else if (core_ready) begin
                ready_flag <= 1'b1;
            end
            if (write_fault_evt) begin
                write_fault_flag <= 1'b1;
            end else if (cmd_start || soft_reset_active) begin
                write_fault_flag <= 1'b0;
            end
            if (fixed_data_evt) begin
                fixed_data_flag <= 1'b1;
            end else if (cmd_start || soft_reset_active) begin
                fixed_data_flag <= 1'b0;
            end
            if (cmd_error_evt || cmd_abort_evt || smart_abort) begin
                error_flag <= 1'b1;
            end else if (cmd_start || soft_reset_active) begin
                error_flag <= 1'b0;
            end
            if (cmd_abort_evt || smart_abort) begin
                aborted_flag <= 1'b1;
            end else if (cmd_start || soft_reset_active) begin
                aborted_flag <= 1'b0;
            end
        end
    end

    // busy leaves the other bits live; the host must ignore them
    assign status_byte = {
        core_busy,
        ready_flag,
        write_fault_flag,
        ready_flag,
        data_request_flag,
        fixed_data_flag,
        1'b0,
        error_flag
    };

    // bit 7 driven low; a shared floppy port may own it
    assign unit_address_readback = {
        1'b0,
        !write_active,
        ~unit_head_select[`ATF_UH_HEAD_HI:`ATF_UH_HEAD_LO],
        !(unit_present[1] && unit_head_select[`ATF_UH_UNIT]),
        !(unit_present[0] && !unit_head_select[`ATF_UH_UNIT])
    };

    // only the primary status read clears; the shadow copy does not
    assign status_rd = reg_rd && (reg_addr == `ATF_OFS_STATUS);

    // pending interrupt; a new event wins over the clearing read
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            irq_pending <= 1'b0;
        end else if (irq_evt) begin
            irq_pending <= 1'b1;
        end else if (status_rd || soft_reset_active) begin
            irq_pending <= 1'b0;
        end
    end

    // masking hides the line but keeps the pending bit
    assign card_irq = irq_pending && !interrupt_mask_n;

    // read data mux
    always @* begin
        case (reg_addr)
            `ATF_OFS_SECTOR: next_rdata = start_sector_lba_low;
            `ATF_OFS_CYL_LO: next_rdata = cylinder_low_lba_mid;
            `ATF_OFS_CYL_HI: next_rdata = cylinder_high_lba_high;
            `ATF_OFS_UNIT_HEAD: next_rdata = unit_head_select;
            `ATF_OFS_STATUS: next_rdata = status_byte;
            `ATF_OFS_CONTROL: next_rdata = status_byte;
            `ATF_OFS_UNIT_ADDR: next_rdata = unit_address_readback;
            default: next_rdata = `ATF_UNMAPPED_READ;
        endcase
    end

    // read data holds until the next read strobe
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            reg_rdata <= `ATF_RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // smart sub-command decode
    assign sig_ok = (cylinder_low_lba_mid == `ATF_SIG_LO) &&
        (cylinder_high_lba_high == `ATF_SIG_HI);

    // unknown feature codes fall to the abort path
    always @* begin
        next_op = `ATF_OP_NONE;
        next_op_ok = 1'b1;
        case (feature_code)
            `ATF_SM_READ_DATA: next_op = `ATF_OP_READ_DATA;
            `ATF_SM_READ_THRESH: next_op = `ATF_OP_READ_THRESH;
            `ATF_SM_AUTOSAVE: next_op = `ATF_OP_AUTOSAVE;
            `ATF_SM_READ_LOG: next_op = `ATF_OP_READ_LOG;
            `ATF_SM_WRITE_LOG: next_op = `ATF_OP_WRITE_LOG;
            `ATF_SM_ENABLE: next_op = `ATF_OP_ENABLE;
            `ATF_SM_DISABLE: next_op = `ATF_OP_DISABLE;
            `ATF_SM_STATUS: next_op = `ATF_OP_NONE;
            default: next_op_ok = 1'b0;
        endcase
        if (!sig_ok) begin
            next_op_ok = 1'b0;
        end
    end

    // a bad code or signature refuses the command as a whole
    assign smart_abort = smart_cmd && !next_op_ok;

    // status code DA reuses op none with a valid strobe
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            smart_op <= `ATF_OP_NONE;
            smart_op_valid <= 1'b0;
        end else begin
            smart_op_valid <= smart_cmd && next_op_ok;
            if (smart_cmd && next_op_ok) begin
                smart_op <= next_op;
            end
        end
    end

    // smart setting: taken from storage after reset release, written back
    always @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            nv_loaded <= 1'b0;
            smart_enabled <= 1'b0;
            smart_nv_load <= 1'b0;
            smart_nv_value <= 1'b0;
        end else begin
            smart_nv_load <= 1'b0;
            // storage read once, on the first clock after reset release, the same edge a host access can first land on
            if (!nv_loaded) begin
                nv_loaded <= 1'b1;
                smart_enabled <= smart_nv_state;
            end else if (smart_cmd && next_op_ok &&
                (next_op == `ATF_OP_ENABLE ||
                next_op == `ATF_OP_DISABLE)) begin
                smart_enabled <= (next_op == `ATF_OP_ENABLE);
                smart_nv_value <= (next_op == `ATF_OP_ENABLE);
                smart_nv_load <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/atf_host_model.sv
// atf_host_model.sv: host side of the task-file register port
// assumes: one access at a time, changed off the falling edge
`timescale 1ns/100ps
`default_nettype none
module atf_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [3:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 4'h0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = (a == 4'h6) ? (v | 8'hA0) : v;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: tb/atf_task_file_properties.sv
// atf_task_file_properties.sv: port checker for atf_task_file
// assumes: bound to the design top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module atf_task_file_properties (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic core_busy,
    input wire logic write_active,
    input wire logic irq_evt,
    input wire logic smart_cmd,
    input wire logic [7:0] feature_code,
    input wire logic [27:0] start_address,
    input wire logic lba_mode,
    input wire logic [3:0] head_number,
    input wire logic soft_reset_active,
    input wire logic interrupt_mask_n,
    input wire logic card_irq,
    input wire logic [2:0] smart_op,
    input wire logic smart_op_valid,
    input wire logic smart_enabled,
    input wire logic smart_nv_load,
    input wire logic aborted_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_status_clear_irq: assert property (
        reg_rd && reg_addr == 4'h7 && !irq_evt |=> !card_irq)
        else $error("status read kept irq");
    a_shadow_keeps_irq: assert property (
        card_irq && reg_rd && reg_addr == 4'hE && !reg_wr
        && !soft_reset_active |=> card_irq)
        else $error("shadow read dropped irq");
    a_irq_masked: assert property (
        interrupt_mask_n |-> !card_irq)
        else $error("irq seen while masked");
    a_control_write: assert property (
        reg_wr && reg_addr == 4'hE |=> {soft_reset_active,
        interrupt_mask_n} == $past(reg_wdata[2:1]))
        else $error("control bits not taken");
    a_head_follow: assert property (
        reg_wr && reg_addr == 4'h6 && !core_busy |-> ##2
        {lba_mode, head_number} == $past({reg_wdata[6], reg_wdata[3:0]}, 2))
        else $error("head or mode not updated");
    a_readback_bits: assert property (
        reg_rd && reg_addr == 4'hF |=> reg_rdata[6:2] ==
        {!$past(write_active), ~$past(head_number)})
        else $error("readback bits wrong");
    a_bad_signature: assert property (
        smart_cmd && start_address[23:8] != 16'hC24F
        |=> aborted_flag && !smart_op_valid)
        else $error("bad signature not aborted");
    a_smart_enable: assert property (
        smart_cmd && feature_code == 8'hD8 && start_address[23:8] == 16'hC24F
        |=> smart_op_valid && smart_op == 3'h6 && smart_enabled && smart_nv_load)
        else $error("enable not carried out");
    c_smart_op: cover property (smart_op_valid);
    c_irq_cleared: cover property (card_irq ##1 !card_irq);
    c_soft_reset: cover property ($rose(soft_reset_active));
endmodule
`default_nettype wire

// File: tb/atf_task_file_tb.sv
// atf_task_file_tb.sv: self-checking bench for atf_task_file
// assumes: host model drives the register port, bench the core side
`timescale 1ns/100ps
`default_nettype none
module atf_task_file_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    wire [3:0] reg_addr;
    wire reg_rd, reg_wr, smart_nv_load, lba_mode, unit_select_bit;
    wire [7:0] reg_wdata, reg_rdata;
    logic core_busy, core_ready, data_request_flag, write_fault_evt;
    logic fixed_data_evt, cmd_error_evt, cmd_abort_evt, cmd_start;
    logic write_active, irq_evt, smart_cmd;
    logic smart_nv_state = 1'b1;
    logic [1:0] unit_present;
    logic [7:0] feature_code, d;
    wire soft_reset_active, interrupt_mask_n, card_irq, smart_op_valid;
    wire smart_enabled, aborted_flag, smart_nv_value;
    wire [27:0] start_address;
    wire [3:0] head_number;
    wire [2:0] smart_op;
    logic [19:0] row;
    logic [11:0] x;
    // rows: offset, write byte, expected read byte
    logic [99:0] rows = 100'h3_12_12_4_4F_4F_5_C2_C2_6_05_A5_6_53_F3;
    // feature code then operation number
    logic [95:0] codes = 96'hD01_D12_D23_D54_D65_D86_D97_DA0;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    atf_task_file atf_task_file_inst (.clk_sys, .arst_n, .reg_addr,
        .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .core_busy, .core_ready,
        .data_request_flag, .write_fault_evt, .fixed_data_evt,
        .cmd_error_evt, .cmd_abort_evt, .cmd_start, .write_active,
        .unit_present, .irq_evt, .smart_cmd, .feature_code, .smart_nv_state,
        .smart_nv_load, .smart_nv_value, .start_address, .lba_mode,
        .head_number, .unit_select_bit, .soft_reset_active,
        .interrupt_mask_n, .card_irq, .smart_op, .smart_op_valid,
        .smart_enabled, .aborted_flag);
    atf_host_model atf_host_model_inst (.clk_sys, .reg_rdata, .reg_addr,
        .reg_rd, .reg_wr, .reg_wdata);
    initial forever #20 clk_sys = ~clk_sys;
    // non-volatile cell: keeps the smart setting across resets
    always @(posedge clk_sys) begin
        if (smart_nv_load) begin
            smart_nv_state <= smart_nv_value;
        end
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [27:0] g, input logic [27:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic ck8(input logic [7:0] g, input logic [7:0] e);
        chk({20'h0, g}, {20'h0, e});
    endtask
    task automatic ck1(input logic g, input logic e);
        chk({27'h0, g}, {27'h0, e});
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] v);
        atf_host_model_inst.wr(a, v);
    endtask
    task automatic r(input logic [3:0] a, input logic [7:0] e);
        atf_host_model_inst.rd(a, d);
        ck8(d, e);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic smart(input logic [7:0] f, input logic ok,
                         input logic [2:0] op);
        feature_code = f;
        pulse(smart_cmd);
        ck1(smart_op_valid, ok);
        if (ok)
            ck8({5'h0, smart_op}, {5'h0, op});
        else
            ck1(aborted_flag, 1'b1);
    endtask
    initial begin
        {core_busy, core_ready, data_request_flag, write_fault_evt} = '0;
        {fixed_data_evt, cmd_error_evt, cmd_abort_evt, cmd_start} = '0;
        {write_active, irq_evt, smart_cmd} = '0;
        unit_present = 2'b11;
        feature_code = 8'h00;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        ck1(smart_enabled, 1'b1);
        ck1(interrupt_mask_n, 1'b0);
        r(4'h6, 8'hA0);
        r(4'h7, 8'h00);
        r(4'h1, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            row = rows[99 - 20 * i -: 20];
            w(row[19:16], row[15:8]);
            r(row[19:16], row[7:0]);
        end
        chk(start_address, 28'h3C24F12);
        ck1(lba_mode, 1'b1);
        ck1(unit_select_bit, 1'b1);
        $display("test table done");
        write_active = 1'b1;
        r(4'hF, 8'h31);
        write_active = 1'b0;
        w(4'h6, 8'h40);
        r(4'hF, 8'h7E);
        $display("test readback done");
        core_ready = 1'b1;
        data_request_flag = 1'b1;
        pulse(write_fault_evt);
        pulse(fixed_data_evt);
        pulse(cmd_error_evt);
        r(4'h7, 8'h7D);
        core_busy = 1'b1;
        w(4'h3, 8'hAA);
        r(4'hE, 8'hFD);
        core_busy = 1'b0;
        r(4'h3, 8'h12);
        pulse(cmd_start);
        data_request_flag = 1'b0;
        r(4'h7, 8'h50);
        pulse(cmd_abort_evt);
        ck1(aborted_flag, 1'b1);
        r(4'h7, 8'h51);
        pulse(cmd_start);
        $display("test status done");
        pulse(irq_evt);
        ck1(card_irq, 1'b1);
        r(4'hE, 8'h50);
        ck1(card_irq, 1'b1);
        r(4'h7, 8'h50);
        ck1(card_irq, 1'b0);
        w(4'hE, 8'h02);
        pulse(irq_evt);
        ck1(card_irq, 1'b0);
        w(4'hE, 8'h00);
        ck1(card_irq, 1'b1);
        $display("test irq done");
        w(4'hE, 8'h04);
        repeat (3) @(negedge clk_sys);
        ck1(soft_reset_active, 1'b1);
        w(4'hE, 8'h00);
        ck1(soft_reset_active, 1'b0);
        r(4'h3, 8'h12);
        $display("test soft reset done");
        // signature 4F/C2 already loaded by the table
        for (int i = 0; i < 8; i++) begin
            x = codes[95 - 12 * i -: 12];
            smart(x[11:4], 1'b1, x[2:0]);
        end
        ck1(smart_enabled, 1'b0);
        ck1(smart_nv_value, 1'b0);
        smart(8'hD3, 1'b0, 3'h0);
        pulse(cmd_start);
        w(4'h4, 8'h00);
        smart(8'hD8, 1'b0, 3'h0);
        r(4'h7, 8'h51);
        $display("test smart done");
        w(4'h4, 8'h4F);
        smart(8'hD8, 1'b1, 3'h6);
        ck1(smart_nv_value, 1'b1);
        w(4'hE, 8'h02);
        @(negedge clk_sys);
        arst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        ck1(smart_enabled, 1'b1);
        ck1(interrupt_mask_n, 1'b0);
        r(4'h3, 8'h00);
        r(4'h7, 8'h50);
        $display("test mid reset done");
        summarize();
    end
endmodule
bind atf_task_file atf_task_file_properties atf_task_file_properties_inst (
    .clk_sys, .arst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .core_busy, .write_active, .irq_evt, .smart_cmd, .feature_code,
    .start_address, .lba_mode, .head_number, .soft_reset_active,
    .interrupt_mask_n, .card_irq, .smart_op, .smart_op_valid,
    .smart_enabled, .smart_nv_load, .aborted_flag);
`default_nettype wire
